// file: logic/lrdc_ext_timer.sv
// Conversion-extension timer for series-resistance cancellation
`timescale 1ns/1ps
module lrdc_ext_timer
  import lrdc_pkg::*;
#(
  parameter int CYCLES = EXT_CYCLES
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             busy_r;
  logic             busy_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (start)
    begin
      cnt_nxt  = CNT_W'(CYCLES - 1);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r == '0)
        busy_nxt = 1'b0;
      else
        cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;

endmodule

// file: logic/lrdc_pkg.sv
// Shared constants, types and helpers for the low-alert and diode calibration block
package lrdc_pkg;

  localparam int           NUM_CH       = 8;
  localparam int           NUM_REMOTE   = 7;
  localparam int           CH_W         = 3;
  localparam int           TEMP_W       = 11;
  localparam int           CODE_W       = 5;
  localparam int           MILLI_W      = 11;

  localparam logic [7:0]   ADDR_LOW_FLAGS   = 8'h47;
  localparam logic [7:0]   ADDR_CANCEL      = 8'h4A;
  localparam logic [7:0]   ADDR_IDEAL_CODE  = 8'h4B;
  localparam logic [7:0]   ADDR_IDEAL_SEL   = 8'h4C;

  localparam logic [7:0]   LOW_FLAGS_RST    = 8'h00;
  localparam logic [6:0]   CANCEL_RST       = 7'h00;
  localparam logic [6:0]   IDEAL_SEL_RST    = 7'h00;
  localparam logic [4:0]   IDEAL_CODE_DEF   = 5'h09;
  localparam logic [10:0]  IDEAL_MILLI_BASE = 11'h3E7;
  localparam logic [7:0]   RDATA_NONE       = 8'h00;

  localparam logic [CH_W-1:0] LOCAL_CH      = 3'h0;
  localparam logic [CH_W-1:0] TOP_REMOTE_CH = 3'h7;
  localparam int           LOCAL_FLAG_BIT   = 6;

  localparam int           CLK_HZ           = 10_000_000;
  localparam int           EXT_TIME_MS      = 125;
  localparam int           EXT_CYCLES       = (EXT_TIME_MS * (CLK_HZ / 1000));

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [7:0]          addr;
    logic [7:0]          wdata;
  } lrdc_reg_req_s;

  typedef struct packed {
    logic                      valid;
    logic [CH_W-1:0]           ch;
    logic signed [TEMP_W-1:0]  temp;
    logic signed [TEMP_W-1:0]  low_limit;
  } lrdc_result_s;

  // Flag position of a channel: remote 7 on top, local just below it
  function automatic logic [7:0] lrdc_flag_mask(input logic [CH_W-1:0] ch);
    logic [7:0] m;
    m = 8'h00;
    if (ch == TOP_REMOTE_CH)
      m[7] = 1'b1;
    else if (ch == LOCAL_CH)
      m[LOCAL_FLAG_BIT] = 1'b1;
    else
      m[ch - 3'h1] = 1'b1;
    return m;
  endfunction

endpackage

// file: logic/lrdc_top.sv
// Low-alert flags, ideality selection and resistance-cancellation control
//
// Summary of operation
// - Set channel low flag when temperature below limit
// - Flag bits: remote7, local, remote6 to remote1
// - All low flags reset to zero
// - Read clears flags; next conversion sets again
// - Remote channels default to ideality 1.008
// - Per-channel choice: default or programmed ideality
// - Ideality code at 0x4B, five low bits
// - Code decodes linearly from 0.999, step 0.001
// - Independent cancellation enable per remote channel
// - Cancellation register at 0x4A, resets zero
// - Cancellation lengthens remote conversion by 125ms
`timescale 1ns/1ps
module lrdc_top
  import lrdc_pkg::*;
#(
  parameter int EXT_CNT = EXT_CYCLES
)(
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire lrdc_reg_req_s                     reg_req,
  output logic [7:0]                             reg_rdata,
  input  wire lrdc_result_s                      conv_res,
  input  wire logic                              conv_start,
  input  wire logic [CH_W-1:0]                   conv_start_ch,
  output logic                                   conv_extend,
  output logic [NUM_REMOTE-1:0]                  cancel_en,
  output logic [NUM_REMOTE-1:0][CODE_W-1:0]      ideality_code_out,
  output logic [NUM_REMOTE-1:0][MILLI_W-1:0]     ideality_milli
);

  // Register state
  logic [7:0]                           low_flags_r;
  logic [7:0]                           low_flags_nxt;
  logic [NUM_REMOTE-1:0]                cancel_r;
  logic [NUM_REMOTE-1:0]                cancel_nxt;
  logic [NUM_REMOTE-1:0]                sel_r;
  logic [NUM_REMOTE-1:0]                sel_nxt;
  logic [CODE_W-1:0]                    code_r;
  logic [CODE_W-1:0]                    code_nxt;
  logic [7:0]                           rdata_r;
  logic [7:0]                           rdata_nxt;

  // Applied calibration per remote channel
  logic [NUM_REMOTE-1:0][CODE_W-1:0]    app_code_r;
  logic [NUM_REMOTE-1:0][CODE_W-1:0]    app_code_nxt;
  logic [NUM_REMOTE-1:0][MILLI_W-1:0]   milli_r;
  logic [NUM_REMOTE-1:0][MILLI_W-1:0]   milli_nxt;

  logic                                 ext_start;
  logic [7:0]                           set_mask;
  logic                                 rd_flags;

  // Thousandths value of the default factor, loaded at reset
  localparam logic [MILLI_W-1:0] MILLI_DEF =
    MILLI_W'(IDEAL_MILLI_BASE + MILLI_W'(IDEAL_CODE_DEF));

  // Events of this cycle: a low result and a read of the flags
  always_comb
  begin
    set_mask = 8'h00;
    if (conv_res.valid && (conv_res.temp < conv_res.low_limit))
      set_mask = lrdc_flag_mask(conv_res.ch);
    rd_flags = reg_req.rd && (reg_req.addr == ADDR_LOW_FLAGS);
  end

  // Flag register: cleared by a completed read, set again by a result
  always_comb
  begin
    low_flags_nxt = low_flags_r;
    if (rd_flags)
      low_flags_nxt = 8'h00;
    // A set in the clearing cycle survives the clear
    low_flags_nxt = low_flags_nxt | set_mask;
  end

  // Cancellation enables, one per remote channel
  always_comb
  begin
    cancel_nxt = cancel_r;
    if (reg_req.wr && (reg_req.addr == ADDR_CANCEL))
      cancel_nxt = reg_req.wdata[NUM_REMOTE-1:0];
  end

  // Ideality code and per-channel choice; unused upper bits are dropped
  always_comb
  begin
    sel_nxt  = sel_r;
    code_nxt = code_r;
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        ADDR_IDEAL_CODE: code_nxt = reg_req.wdata[CODE_W-1:0];
        ADDR_IDEAL_SEL:  sel_nxt  = reg_req.wdata[NUM_REMOTE-1:0];
        default:         code_nxt = code_r;
      endcase
    end
  end

  // Read data is captured before a clear in the same cycle
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        ADDR_LOW_FLAGS:  rdata_nxt = low_flags_r;
        ADDR_CANCEL:     rdata_nxt = {1'b0, cancel_r};
        ADDR_IDEAL_CODE: rdata_nxt = {3'h0, code_r};
        ADDR_IDEAL_SEL:  rdata_nxt = {1'b0, sel_r};
        default:         rdata_nxt = RDATA_NONE;
      endcase
    end
  end

  // Per-channel ideality choice and linear decode to thousandths
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REMOTE; gi++)
    begin : g_ch
      always_comb
      begin
        app_code_nxt[gi] = sel_r[gi] ? code_r : IDEAL_CODE_DEF;
        milli_nxt[gi]    = IDEAL_MILLI_BASE + MILLI_W'(app_code_nxt[gi]);
      end
    end
  endgenerate

  // Remote conversion with cancellation on gets the extension window
  always_comb
  begin
    ext_start = 1'b0;
    // The local channel has no cancellation enable
    if (conv_start && (conv_start_ch != LOCAL_CH))
      ext_start = cancel_r[conv_start_ch - 3'h1];
  end

  // A start during a running window restarts it at the full count
  lrdc_ext_timer #(
    .CYCLES (EXT_CNT)
  ) u_ext (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (ext_start),
    .busy    (conv_extend)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      low_flags_r <= LOW_FLAGS_RST;
    end
    else
    begin
      low_flags_r <= low_flags_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cancel_r <= CANCEL_RST;
    end
    else
    begin
      cancel_r <= cancel_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_r  <= IDEAL_SEL_RST;
      code_r <= IDEAL_CODE_DEF;
    end
    else
    begin
      sel_r  <= sel_nxt;
      code_r <= code_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r <= RDATA_NONE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Applied calibration; reset gives every channel the default factor
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      app_code_r <= {NUM_REMOTE{IDEAL_CODE_DEF}};
      milli_r    <= {NUM_REMOTE{MILLI_DEF}};
    end
    else
    begin
      app_code_r <= app_code_nxt;
      milli_r    <= milli_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign cancel_en         = cancel_r;
  assign ideality_code_out = app_code_r;
  assign ideality_milli    = milli_r;

endmodule

// file: test/lrdc_host_model.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module lrdc_host_model
  import lrdc_pkg::*;
(
  input wire logic      clk,
  output lrdc_reg_req_s req
);
  initial req = '0;
  // One-cycle strobe launched after a falling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
endmodule

// file: test/lrdc_props.sv
// Port-level assertions for the low-alert and calibration block
`timescale 1ns/1ps
module lrdc_props
  import lrdc_pkg::*;
#(
  parameter int EXT_CNT = EXT_CYCLES
)(
  input wire logic                               clk,
  input wire logic                               sys_rst,
  input wire lrdc_reg_req_s                      reg_req,
  input wire logic [7:0]                         reg_rdata,
  input wire lrdc_result_s                       conv_res,
  input wire logic                               conv_start,
  input wire logic [CH_W-1:0]                    conv_start_ch,
  input wire logic                               conv_extend,
  input wire logic [NUM_REMOTE-1:0]              cancel_en,
  input wire logic [NUM_REMOTE-1:0][CODE_W-1:0]  ideality_code_out,
  input wire logic [NUM_REMOTE-1:0][MILLI_W-1:0] ideality_milli
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rd47 = reg_req.rd && reg_req.addr == ADDR_LOW_FLAGS;
  wire low  = conv_res.valid && conv_res.temp < conv_res.low_limit;

  // Length of the current run of the extension flag
  logic [31:0] ext_run;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ext_run <= '0;
    else if (conv_extend)
      ext_run <= ext_run + 32'h1;
    else
      ext_run <= '0;
  end

  a_ext_start: assert property (conv_start && conv_start_ch != LOCAL_CH &&
    cancel_en[conv_start_ch - 3'h1] |=> conv_extend) else $error("extension missing");
  a_ext_cause: assert property ($rose(conv_extend) |-> $past(conv_start) &&
    $past(conv_start_ch) != LOCAL_CH) else $error("extension without remote start");
  a_ext_length: assert property ($fell(conv_extend) |->
    ext_run >= EXT_CNT) else $error("extension too short");
  a_cancel_write: assert property (reg_req.wr && reg_req.addr == ADDR_CANCEL |=>
    cancel_en == $past(reg_req.wdata[6:0])) else $error("cancel enables wrong");
  a_cancel_read: assert property (reg_req.rd && reg_req.addr == ADDR_CANCEL |=>
    reg_rdata == {1'b0, $past(cancel_en)}) else $error("cancel readback wrong");
  a_code_milli: assert property (ideality_milli[0] == IDEAL_MILLI_BASE +
    ideality_code_out[0]) else $error("ideality decode wrong");
  a_code_read: assert property (reg_req.rd && reg_req.addr == ADDR_IDEAL_CODE |=>
    reg_rdata[7:5] == 3'h0) else $error("ideality upper bits not zero");
  a_flag_top: assert property ((low && conv_res.ch == TOP_REMOTE_CH) ##1 !rd47
    ##1 rd47 |=> reg_rdata[7]) else $error("top remote flag missing");
  a_flag_clear: assert property ((rd47 && !conv_res.valid) ##1 !conv_res.valid ##1 rd47
    |=> reg_rdata == 8'h00) else $error("flags not cleared by read");

  cover property (conv_extend ##1 !conv_extend);
  cover property (rd47 ##1 reg_rdata != 8'h00);
  cover property (reg_req.wr && reg_req.addr == ADDR_IDEAL_SEL);
  cover property (rd47 && low);
endmodule

bind lrdc_top lrdc_props #(.EXT_CNT(EXT_CNT)) u_props (.clk, .sys_rst, .reg_req, .reg_rdata,
  .conv_res, .conv_start, .conv_start_ch, .conv_extend, .cancel_en, .ideality_code_out,
  .ideality_milli);

// file: test/lrdc_top_tb.sv
// Self-checking bench for the low-alert and calibration block
`timescale 1ns/1ps
module lrdc_top_tb
  import lrdc_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, conv_start = 1'b0, tk = 1'b0;
  logic [CH_W-1:0]                    conv_start_ch = '0;
  lrdc_result_s                       conv_res = '0;
  lrdc_reg_req_s                      reg_req;
  logic [7:0]                         reg_rdata, m, exp_q[$];
  logic                               conv_extend;
  logic [NUM_REMOTE-1:0]              cancel_en;
  logic [NUM_REMOTE-1:0][CODE_W-1:0]  code_o;
  logic [NUM_REMOTE-1:0][MILLI_W-1:0] milli;
  logic [4:0]                         c;
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 32'h09F90CD8, n;

  always #50 clk = ~clk;
  lrdc_host_model hm (.clk, .req(reg_req));
  lrdc_top #(.EXT_CNT(10)) dut (.clk, .sys_rst, .reg_req, .reg_rdata, .conv_res, .conv_start,
    .conv_start_ch, .conv_extend, .cancel_en, .ideality_code_out(code_o), .ideality_milli(milli));

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    hm.acc(1'b0, a, 8'h00);
  endtask
  task automatic conv(input logic [2:0] ch, input logic d);
    logic signed [10:0] t;
    t = 11'($random(seed) % 500);
    @(negedge clk);
    conv_res = '{1'b1, ch, t, t + 11'(d)};
    @(negedge clk);
    conv_res.valid = 1'b0;
  endtask
  task automatic start(input logic [2:0] ch, input int e);
    int k;
    k = 0;
    @(negedge clk);
    {conv_start, conv_start_ch} = {1'b1, ch};
    @(negedge clk);
    conv_start = 1'b0;
    repeat (14)
    begin
      k += int'(conv_extend);
      @(negedge clk);
    end
    chk(11'(k), 11'(e));
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) tk <= reg_req.rd;
  // Read data is looked at one cycle after its strobe
  always @(negedge clk)
    if (tk)
      chk(11'(reg_rdata), 11'(exp_q.pop_front()));
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rd(ADDR_LOW_FLAGS, 8'h00);
    rd(ADDR_CANCEL, 8'h00);
    rd(ADDR_IDEAL_SEL, 8'h00);
    for (n = 0; n < 7; n++)
      chk(milli[n], 11'h3F0);
    m = 8'h00;
    for (n = 0; n < 8; n++)
    begin
      conv(n[2:0], n != 3);
      if (n != 3)
        m |= n == 7 ? 8'h80 : n == 0 ? 8'h40 : 8'h01 << (n - 1);
    end
    rd(ADDR_LOW_FLAGS, m);
    rd(ADDR_LOW_FLAGS, 8'h00);
    conv(3'h5, 1'b1);
    rd(ADDR_LOW_FLAGS, 8'h10);
    // Result and read in one cycle: the read sees the old value, the set stays
    fork
      conv(3'h2, 1'b1);
      rd(ADDR_LOW_FLAGS, 8'h00);
    join
    rd(ADDR_LOW_FLAGS, 8'h02);
    hm.acc(1'b1, ADDR_CANCEL, 8'hFF);
    chk(11'(cancel_en), 11'h07F);
    rd(ADDR_CANCEL, 8'h7F);
    start(3'h0, 0);
    start(3'h3, 10);
    hm.acc(1'b1, ADDR_CANCEL, 8'h00);
    start(3'h3, 0);
    hm.acc(1'b1, ADDR_IDEAL_SEL, 8'hC5);
    for (n = 0; n < 4; n++)
    begin
      c = n == 0 ? 5'h00 : n == 1 ? 5'h1F : n == 2 ? 5'h09 : 5'($random(seed));
      hm.acc(1'b1, ADDR_IDEAL_CODE, {3'h7, c});
      @(negedge clk);
      chk(milli[0], 11'h3E7 + 11'(c));
      chk(milli[1], 11'h3F0);
      chk(11'(code_o[2]), 11'(c));
      chk(11'(code_o[1]), 11'h009);
      rd(ADDR_IDEAL_CODE, {3'h0, c});
    end
    rd(ADDR_IDEAL_SEL, 8'h45);
    hm.acc(1'b1, 8'h4D, 8'h5A);
    rd(8'h4D, 8'h00);
    @(negedge clk);
    report_and_stop();
  end
endmodule
